// ### design/debounced_isolated_input_port.sv
// isolated input port: window decode, control word, debounced channels
`timescale 1ns/10ps
module debounced_isolated_input_port #(
    parameter int NUM_CH = dio_pkg::NUM_CH,
    parameter int CNT_W = dio_pkg::DEB_CNT_W,
    parameter int unsigned DELAY_CYC [dio_pkg::DEB_NUM] = '{dio_pkg::DEB_C0, dio_pkg::DEB_C1,
        dio_pkg::DEB_C2, dio_pkg::DEB_C3, dio_pkg::DEB_C4, dio_pkg::DEB_C5, dio_pkg::DEB_C6,
        dio_pkg::DEB_C7}
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [dio_pkg::ADDR_W-1:0] io_base,
    input wire logic [dio_pkg::ADDR_W-1:0] mem_base,
    input wire logic req_valid,
    input wire logic req_io,
    input wire logic req_write,
    input wire logic [dio_pkg::ADDR_W-1:0] req_addr,
    input wire logic [3:0] req_be_n,
    input wire logic [dio_pkg::DATA_W-1:0] req_wdata,
    output logic req_hit,
    output logic rsp_valid,
    output logic [dio_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic [NUM_CH-1:0] input_energised,
    output logic fail_indicator_on
);
    import dio_pkg::*;

    // ------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------
    function automatic logic win_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
        // low address bits ignored so every longword aliases the first
        win_hit = (addr[ADDR_W-1:WIN_LSB] == base[ADDR_W-1:WIN_LSB]);
    endfunction : win_hit

    logic io_hit;
    logic mem_hit;
    logic wr_hit;
    logic fail_indicator_bit;
    logic [DEB_SEL_W-1:0] debounce_select;
    logic [NUM_CH-1:0] stable;
    logic [DATA_W-1:0] read_word;
    logic [CNT_W-1:0] limit;

    assign io_hit = req_valid && req_io && win_hit(req_addr, io_base);
    assign mem_hit = req_valid && !req_io && win_hit(req_addr, mem_base);
    assign req_hit = io_hit || mem_hit;
    assign wr_hit = req_hit && req_write;

    // ------------------------------------------------------------
    // lane decode
    // ------------------------------------------------------------
    // enables are active low; a disabled lane leaves its field alone
    function automatic logic lane_wr(input logic hit, input logic [3:0] be_n, input int lane);
        lane_wr = hit && !be_n[lane];
    endfunction : lane_wr

    logic fail_wr;
    logic sel_wr;
    assign fail_wr = lane_wr(wr_hit, req_be_n, LANE_FAIL);
    assign sel_wr = lane_wr(wr_hit, req_be_n, LANE_DEB);

    // ------------------------------------------------------------
    // control and status word
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fail_indicator_bit <= FAIL_BIT_RST;
        end else if (fail_wr) begin
            fail_indicator_bit <= req_wdata[FAIL_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            debounce_select <= DEB_SEL_RST;
        end else if (sel_wr) begin
            debounce_select <= req_wdata[DEB_SEL_LSB +: DEB_SEL_W];
        end
    end

    // indicator lit while the bit is low
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fail_indicator_on <= 1'b1;
        end else begin
            fail_indicator_on <= !fail_indicator_bit;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        read_word = '0; // reserved bits stay low
        read_word[FAIL_BIT] = fail_indicator_bit;
        read_word[DEB_SEL_LSB +: DEB_SEL_W] = debounce_select;
        read_word[INPUT_LSB +: NUM_CH] = ~stable;
    end

    // all lanes returned on every read; reads have no side effect
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= req_hit;
            rsp_rdata <= (req_hit && !req_write) ? read_word : '0;
        end
    end

    // ------------------------------------------------------------
    // debounce channels
    // ------------------------------------------------------------
    assign limit = CNT_W'(DELAY_CYC[debounce_select]);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            channel_debounce #(
                .CNT_W(CNT_W)
            ) u_deb (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .raw(input_energised[ch]),
                .limit(limit),
                .stable(stable[ch])
            );
            // a channel may only settle on the level its pin actually held
            AST_CH_TO_RAW: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $changed(stable[ch]) |-> (stable[ch] == $past(input_energised[ch])))
                else $error("channel settled on a level its input never held");
            AST_CH_FROM_DIFFER: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $changed(stable[ch]) |-> ($past(input_energised[ch]) != $past(stable[ch])))
                else $error("channel flipped while its input matched");
        end
    endgenerate

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_IO_OUTSIDE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_valid && req_io && req_addr[ADDR_W-1:WIN_LSB] != io_base[ADDR_W-1:WIN_LSB]) |-> !req_hit)
        else $error("io access outside window was claimed");
    AST_MEM_INSIDE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_valid && !req_io && req_addr[ADDR_W-1:WIN_LSB] == mem_base[ADDR_W-1:WIN_LSB]) |-> req_hit ##1 rsp_valid)
        else $error("memory access inside window not answered");
    AST_ALIAS_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_hit && !req_write) |=> (rsp_valid && rsp_rdata == $past(read_word)))
        else $error("aliased read returned wrong word");
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rsp_valid |-> ((rsp_rdata & RSVD_MASK) == '0))
        else $error("reserved bits read nonzero");
    AST_FAIL_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_hit && !req_be_n[LANE_FAIL]) |-> ##2 (fail_indicator_on == !$past(req_wdata[FAIL_BIT], 2)))
        else $error("fail indicator did not follow write");
    AST_SEL_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_hit && !req_be_n[LANE_DEB]) |=> (debounce_select == $past(req_wdata[DEB_SEL_LSB +: DEB_SEL_W])))
        else $error("debounce select did not follow write");
    AST_SEL_KEEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_hit && req_be_n[LANE_DEB]) |=> $stable(debounce_select))
        else $error("debounce select changed without its lane");
    AST_POLARITY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_hit && !req_write) |=> (rsp_rdata[INPUT_LSB +: NUM_CH] == ~$past(stable)))
        else $error("input data not inverted");
    AST_LIMIT_MAP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (debounce_select == DEB_SEL_RST) |-> (limit == CNT_W'(DELAY_CYC[0])))
        else $error("shortest delay not selected");
    AST_HIT_NEEDS_VALID: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !req_valid |-> !req_hit)
        else $error("idle bus was claimed");
    AST_IO_INSIDE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_valid && req_io && req_addr[ADDR_W-1:WIN_LSB] == io_base[ADDR_W-1:WIN_LSB]) |-> req_hit)
        else $error("io access inside window not claimed");
    AST_MEM_OUTSIDE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_valid && !req_io && req_addr[ADDR_W-1:WIN_LSB] != mem_base[ADDR_W-1:WIN_LSB]) |-> !req_hit)
        else $error("memory access outside window was claimed");
    AST_RSP_AFTER_HIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rsp_valid |-> $past(req_hit))
        else $error("answer without a claimed access");
    AST_NO_RSP_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !req_hit |=> !rsp_valid)
        else $error("unclaimed access answered");
    AST_WRITE_RSP_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_hit |=> (rsp_valid && rsp_rdata == '0))
        else $error("write answer carried data");
    AST_IDLE_DATA_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !rsp_valid |-> (rsp_rdata == '0))
        else $error("read data left on idle bus");
    AST_FAIL_KEEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_hit && !fail_wr) |=> $stable(fail_indicator_bit))
        else $error("fail bit changed without its lane");
    AST_READ_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (req_hit && !req_write) |=> ($stable(fail_indicator_bit) && $stable(debounce_select)))
        else $error("read changed the control word");
    AST_LAMP_FOLLOWS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fail_indicator_on == !$past(fail_indicator_bit))
        else $error("fail indicator does not follow its bit");

    for (genvar s = 0; s < DEB_NUM; s++) begin : g_sel_chk
        AST_LIMIT_EACH: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (debounce_select == DEB_SEL_W'(s)) |-> (limit == CNT_W'(DELAY_CYC[s])))
            else $error("debounce count does not match its select code");
    end

    // ------------------------------------------------------------
    // reset defaults
    // ------------------------------------------------------------
    // looked at one edge late so the first edge never meets unset state
    AST_RST_LAMP: assert property (@(posedge ref_clk)
        sys_rst |=> (fail_indicator_on && !fail_indicator_bit))
        else $error("fail indicator not lit after reset");
    AST_RST_SEL: assert property (@(posedge ref_clk)
        sys_rst |=> (debounce_select == DEB_SEL_RST && !rsp_valid && stable == '0))
        else $error("control word or channels not at reset value");

    COV_CTRL_WRITE: cover property (@(posedge ref_clk) disable iff (sys_rst) sel_wr);
    COV_MEM_READ: cover property (@(posedge ref_clk) disable iff (sys_rst) mem_hit && !req_write);
    COV_CH_FLIP: cover property (@(posedge ref_clk) disable iff (sys_rst) $changed(stable));
    COV_FAIL_OFF: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(fail_indicator_on));
    COV_ALIAS_HIGH: cover property (@(posedge ref_clk) disable iff (sys_rst) req_hit && req_addr[WIN_LSB-1:2] != '0);
endmodule : debounced_isolated_input_port

// ### design/dio_pkg.sv
// constants for the debounced isolated input port
package dio_pkg;
    // ------------------------------------------------------------
    // clock and debounce timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int DEB_T0_NS = 1000;
    localparam int DEB_T1_NS = 128000;
    localparam int DEB_T2_NS = 256000;
    localparam int DEB_T3_NS = 512000;
    localparam int DEB_T4_NS = 3070000;
    localparam int DEB_T5_NS = 6130000;
    localparam int DEB_T6_NS = 9180000;
    localparam int DEB_T7_NS = 12250000;
    // least times, so round up
    localparam int DEB_C0 = (DEB_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C1 = (DEB_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C2 = (DEB_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C3 = (DEB_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C4 = (DEB_T4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C5 = (DEB_T5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C6 = (DEB_T6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_C7 = (DEB_T7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_CNT_W = 22;
    localparam int DEB_SEL_W = 3;
    localparam int DEB_NUM = 8;

    // ------------------------------------------------------------
    // address window and register layout
    // ------------------------------------------------------------
    localparam int WINDOW_BYTES = 64;
    localparam int WIN_LSB = $clog2(WINDOW_BYTES);
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 16;
    localparam logic [1:0] INPUT_WORD_OFS = 2'h0;
    localparam logic [1:0] CTRL_WORD_OFS = 2'h2;
    localparam int INPUT_LSB = 8 * INPUT_WORD_OFS;
    localparam int CTRL_LSB = 8 * CTRL_WORD_OFS;
    localparam int FAIL_BIT = 24;
    localparam int DEB_SEL_LSB = 16;
    localparam int LANE_FAIL = 3;
    localparam int LANE_DEB = 2;
    localparam logic [DATA_W-1:0] RSVD_MASK = 32'hfef8_0000;
    localparam logic FAIL_BIT_RST = 1'b0;
    localparam logic [DEB_SEL_W-1:0] DEB_SEL_RST = 3'h0;
endpackage : dio_pkg

// ### design/channel_debounce.sv
// one input channel debounce filter
`timescale 1ns/10ps
module channel_debounce #(
    parameter int CNT_W = 22
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic raw,
    input wire logic [CNT_W-1:0] limit,
    output logic stable
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] held;
    logic [CNT_W-1:0] eff;

    // limit is frozen at the first differing cycle of a transition
    assign eff = (cnt == '0) ? limit : held;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            held <= '0;
        end else if (cnt == '0 && raw != stable) begin
            held <= limit;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
            stable <= 1'b0;
        end else if (raw == stable) begin
            cnt <= '0; // bounce restarts the wait
        end else if (cnt + CNT_W'(1) >= eff) begin
            cnt <= '0;
            stable <= raw;
        end else begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    AST_DEB_NO_EARLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $changed(stable) |-> ($past(cnt) + CNT_W'(1) >= $past(eff)))
        else $error("channel flipped before its debounce delay");
    AST_DEB_HELD_FROZEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cnt != '0 && raw != stable) |=> (held == $past(held)))
        else $error("debounce limit changed in mid transition");
endmodule : channel_debounce

// ### sim/pci_host_model.sv
// host-side model: assigns window bases and issues single-longword accesses
`timescale 1ns/10ps
module pci_host_model (
    input wire logic ref_clk,
    output logic [31:0] io_base,
    output logic [31:0] mem_base,
    output logic req_valid,
    output logic req_io,
    output logic req_write,
    output logic [31:0] req_addr,
    output logic [3:0] req_be_n,
    output logic [31:0] req_wdata,
    input wire logic req_hit,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_rdata
);
    // bases are arbitrary 64-byte aligned picks made at configuration time
    initial begin
        io_base = 32'h0000_1c40;
        mem_base = 32'h8000_0400;
        req_valid = 1'b0;
        req_io = 1'b0;
        req_write = 1'b0;
        req_addr = 32'h0;
        req_be_n = 4'hf;
        req_wdata = 32'h0;
    end

    task automatic access(input logic io, input logic wr, input logic [6:0] ofs, input logic [3:0] be_n,
        input logic [31:0] wd, output logic hit, output logic vld, output logic [31:0] rd);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_io <= io;
        req_write <= wr;
        req_addr <= (io ? io_base : mem_base) + {25'h0, ofs};
        req_be_n <= be_n;
        req_wdata <= wd;
        @(posedge ref_clk);
        hit = req_hit;
        req_valid <= 1'b0;
        // released bus inverts address and write data so neither keeps a stale value
        req_addr <= ~req_addr;
        req_wdata <= ~wd;
        @(posedge ref_clk);
        vld = rsp_valid;
        rd = rsp_rdata;
    endtask : access
endmodule : pci_host_model

// ### sim/debounced_isolated_input_port_tb.sv
// self-checking bench for the debounced isolated input port
`timescale 1ns/10ps
module debounced_isolated_input_port_tb;
    import dio_pkg::*;
    typedef struct packed {logic io; logic [6:0] ofs; logic [3:0] be_n; logic [31:0] wd; logic [15:0] hi;
        logic [3:0] ch;} row_s;
    localparam int unsigned DLY [DEB_NUM] = '{2, 4, 6, 8, 10, 12, 14, 16};
    localparam row_s ROWS [10] = '{'{1'b1, 7'd0, 4'h0, 32'hffff_ffff, 16'h0107, 4'd15},
        '{1'b0, 7'd4, 4'h0, 32'h0000_0000, 16'h0000, 4'd0}, '{1'b1, 7'd60, 4'hb, 32'h0103_0000, 16'h0003, 4'd3},
        '{1'b0, 7'd8, 4'h7, 32'h0100_0000, 16'h0103, 4'd10}, '{1'b1, 7'd2, 4'h3, 32'hfe01_ffff, 16'h0001, 4'd1},
        '{1'b0, 7'd63, 4'h0, 32'h00fa_0000, 16'h0002, 4'd2}, '{1'b1, 7'd16, 4'h0, 32'h0104_0000, 16'h0104, 4'd4},
        '{1'b0, 7'd32, 4'h0, 32'h0005_0000, 16'h0005, 4'd5}, '{1'b1, 7'd12, 4'hf, 32'h0106_0000, 16'h0005, 4'd6},
        '{1'b0, 7'd44, 4'h0, 32'h0106_0000, 16'h0106, 4'd7}};
    logic ref_clk, sys_rst, req_valid, req_io, req_write, req_hit, rsp_valid, fail_indicator_on, hit, vld;
    logic [31:0] io_base, mem_base, req_addr, req_wdata, rsp_rdata, data;
    logic [3:0] req_be_n;
    logic [15:0] input_energised, deb, hi;
    int fail_count, cmp_count, n;
    row_s r;

    pci_host_model host (.ref_clk(ref_clk), .io_base(io_base), .mem_base(mem_base), .req_valid(req_valid),
        .req_io(req_io), .req_write(req_write), .req_addr(req_addr), .req_be_n(req_be_n), .req_wdata(req_wdata),
        .req_hit(req_hit), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    debounced_isolated_input_port #(.DELAY_CYC(DLY)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .io_base(io_base), .mem_base(mem_base), .req_valid(req_valid), .req_io(req_io), .req_write(req_write),
        .req_addr(req_addr), .req_be_n(req_be_n), .req_wdata(req_wdata), .req_hit(req_hit),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .input_energised(input_energised),
        .fail_indicator_on(fail_indicator_on));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic rd(input logic io, input logic [6:0] ofs, input logic [3:0] be_n, input logic [31:0] exp);
        host.access(io, 1'b0, ofs, be_n, 32'h0, hit, vld, data);
        check({31'h0, hit & vld}, 32'h1, "read handshake");
        check(data, exp, "read word");
    endtask : rd

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // span covers all rows at the shortened delays with a wide margin
    initial begin
        #100000;
        fail_count++;
        $display("unexpected %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        input_energised = 16'h0;
        fail_count = 0;
        cmp_count = 0;
        deb = 16'h0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check({31'h0, fail_indicator_on}, 32'h1, "lamp after reset");
        rd(1'b1, 7'd0, 4'h0, 32'h0000_ffff);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            host.access(r.io, 1'b1, r.ofs, r.be_n, r.wd, hit, vld, data);
            check({30'h0, hit, vld}, 32'h3, "write handshake");
            check(data, 32'h0, "write answer");
            hi = r.hi;
            rd(~r.io, r.ofs ^ 7'h3c, 4'h0, {hi, ~deb});
            check({31'h0, fail_indicator_on}, {31'h0, ~hi[8]}, "lamp");
            n = DLY[hi[2:0]];
            @(posedge ref_clk);
            input_energised[r.ch] <= ~deb[r.ch];
            repeat (n - 2) @(posedge ref_clk);
            rd(1'b1, r.ofs, 4'h0, {hi, ~deb});
            deb[r.ch] = ~deb[r.ch];
            rd(1'b0, r.ofs, 4'h0, {hi, ~deb});
        end
        // short glitch must not flip the channel
        @(posedge ref_clk);
        input_energised[9] <= 1'b1;
        repeat (n - 1) @(posedge ref_clk);
        input_energised[9] <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rd(1'b1, 7'd1, 4'he, {hi, ~deb});
        // select rewritten mid-transition: the latched delay still rules
        @(posedge ref_clk);
        input_energised[11] <= 1'b1;
        host.access(1'b0, 1'b1, 7'd0, 4'hb, 32'h0, hit, vld, data);
        hi = 16'h0100;
        rd(1'b1, 7'd0, 4'h0, {hi, ~deb});
        repeat (n - 6) @(posedge ref_clk);
        deb[11] = 1'b1;
        rd(1'b1, 7'd0, 4'h0, {hi, ~deb});
        host.access(1'b1, 1'b1, 7'd64, 4'h0, 32'h0, hit, vld, data);
        check({30'h0, hit, vld}, 32'h0, "outside window");
        rd(1'b0, 7'd0, 4'h0, {hi, ~deb});
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        input_energised <= 16'h0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(1'b0, 7'd20, 4'h0, 32'h0000_ffff);
        finish_test();
    end
endmodule : debounced_isolated_input_port_tb
